// file: sc0_channel0.sv
// Serial channel 0: stop, 3-wire, 2-wire open-drain and addressed bus
// modes, reached over APB. Assumes pull-ups on the bus lines and that
// the pin-level resolution is done outside from the enables.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sc0_consts.svh"

// What this block does
// R1 - Stop mode: shift register is plain storage
// R2 - Reset gives stop mode, data pins inputs
// R3 - 3-wire: shift at falling clock, latch drives
// R4 - 3-wire: sample serial input at rising clock
// R5 - After 8 bits stop and set flag
// R6 - Triggers force output latch; only when idle
// R7 - Mode bit 2 selects MSB or LSB first in 3-wire mode only
// R8 - Bit order reversed on bus paths only
// R9 - 2-wire: MSB first on selected open-drain line
// R10 - Board pulls up the open-drain line
// R11 - Bus mode: shift falling, latch rising
// R12 - Bus mode tells address, command, data frames
// R13 - Wake-up in bus mode: flag only on address match
// R14 - Write starts transfer when enabled, clock high
// R15 - Enabling after the write starts nothing
// R16 - Software preloads all-ones before receiving
// R17 - Wake-up keeps pull-down off while receiving
// R18 - Write during busy waits for ready line
// R19 - Idle generated clock stays high
// R20 - Clock port latch bit 1, resets to 1
// R21 - Software keeps clock latch high
// R22 - Data rise, clock high: release detected
// R23 - Data fall, clock high: command detected
// R24 - Acknowledge low for one clock after receive
// R25 - Without wake-up flag at ninth rising edge
// R26 - Serial clock rests high between transfers
module sc0_channel0
    import sc0_pkg::*;
#(
    parameter int CLK_HALF = `SC0_CLK_HALF
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Serial clock pin
    input  wire logic        CH0_CLOCK_PIN_I,
    output logic             CH0_CLOCK_PIN_O,
    output logic             CH0_CLOCK_PIN_OE,
    // Line A: serial output in 3-wire mode, open-drain otherwise
    input  wire logic        BUS_LINE_A_I,
    output logic             BUS_LINE_A_O,
    output logic             BUS_LINE_A_OE,
    // Line B: serial input in 3-wire mode, open-drain otherwise
    input  wire logic        BUS_LINE_B_I,
    output logic             BUS_LINE_B_O,
    output logic             BUS_LINE_B_OE
);

    logic [7:0]  sr_q;
    logic [7:0]  mode_q;
    logic [7:0]  busctl_q;
    logic [7:0]  sva_q;
    logic [7:0]  port_q;
    logic        out_latch_q;
    logic        irq_q;
    logic        release_detected_q;
    logic        command_detected_q;
    logic        match_q;
    sc0_frame_e  frame_q;
    sc0_state_e  state_q;
    logic [3:0]  bits_q;
    logic        gen_q;
    logic [7:0]  gcnt_q;
    logic [3:0]  grise_q;
    logic        clk_p_q;
    logic        dl_p_q;
    logic [2:0]  pins_s;
    logic        clk_s;
    logic        la_s;
    logic        lb_s;
    logic        dl_s;
    logic        sin;
    sc0_mode_e   mode;
    logic        en;
    logic        wakeup_enable;
    logic        bus;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        run;
    logic        wr;
    logic        wr_shift;
    logic        hit;
    logic        lsb_first;
    logic [7:0]  wr_rev;
    logic [7:0]  rd_rev;
    logic [7:0]  wr_ord;
    logic [7:0]  rd_ord;
    logic [3:0]  last;
    logic        done;
    logic        gate_ok;
    logic        od_drive;
    logic [7:0]  rx_next;

    sc0_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk      (MCLK),
        .rst_b    (RST_B),
        .async_in ({CH0_CLOCK_PIN_I, BUS_LINE_B_I, BUS_LINE_A_I}),
        .sync_out (pins_s)
    );

    assign la_s  = pins_s[0];
    assign lb_s  = pins_s[1];
    assign clk_s = pins_s[2];

    assign mode = sc0_mode_e'(mode_q[`SC0_MODE_SEL_HI:`SC0_MODE_SEL_LO]);
    assign en   = mode_q[`SC0_MODE_EN];
    assign wakeup_enable  = busctl_q[`SC0_BC_WAKEUP];
    assign bus  = (mode == SC0_ADDR_BUS);
    assign dl_s = mode_q[`SC0_MODE_LINE] ? lb_s : la_s;
    assign sin  = (mode == SC0_THREE_WIRE) ? lb_s : dl_s;
    assign last = bus ? `SC0_BUS_BITS : `SC0_DATA_BITS;
    assign run  = (state_q == SC0_RUN) && (mode != SC0_STOP);

    // Edges are taken on the resynchronised pin so that both an external
    // master clock and our own generated clock are seen the same way.
    assign sclk_rise = clk_s & ~clk_p_q;
    assign sclk_fall = ~clk_s & clk_p_q;
    assign done      = run && sclk_rise && (bits_q == last - 4'd1);
    assign rx_next   = {sr_q[6:0], sin};
    // Without wake-up every frame flags; with it in bus mode only a matched address
    assign gate_ok   = !(bus && wakeup_enable) || match_q;             // R13 R25

    always_ff @(posedge MCLK) begin
        clk_p_q <= RST_B ? clk_s : 1'b1;
        dl_p_q  <= RST_B ? dl_s : 1'b1;
    end

    // APB decode: zero wait states, error on unmapped offsets
    assign wr       = PSEL && PENABLE && PWRITE;
    assign wr_shift = wr && (PADDR == `SC0_OFF_SHIFT);
    assign hit      = (PADDR == `SC0_OFF_SHIFT) || (PADDR == `SC0_OFF_MODE)
                   || (PADDR == `SC0_OFF_BUSCTL) || (PADDR == `SC0_OFF_SVA)
                   || (PADDR == `SC0_OFF_STATUS) || (PADDR == `SC0_OFF_PORT);
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL && PENABLE && !hit;

    // Bit order is swapped on the bus side; the shifter always runs MSB out
    assign lsb_first = mode_q[`SC0_MODE_LSB] && (mode == SC0_THREE_WIRE);
    generate
        for (genvar i = 0; i < 8; i++) begin : g_rev
            assign wr_rev[i] = PWDATA[7-i];
            assign rd_rev[i] = sr_q[7-i];
        end
    endgenerate
    assign wr_ord = lsb_first ? wr_rev : PWDATA[7:0];          // R7 R8
    assign rd_ord = lsb_first ? rd_rev : sr_q;                 // R8

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                `SC0_OFF_SHIFT:  PRDATA <= {24'h0, rd_ord};
                `SC0_OFF_MODE:   PRDATA <= {24'h0, mode_q};
                `SC0_OFF_BUSCTL: PRDATA <= {24'h0, busctl_q};
                `SC0_OFF_SVA:    PRDATA <= {24'h0, sva_q};
                `SC0_OFF_STATUS: PRDATA <= {24'h0, 1'b0, match_q,
                                            run, frame_q, irq_q,
                                            command_detected_q, release_detected_q};
                `SC0_OFF_PORT:   PRDATA <= {24'h0, port_q};
                default:         PRDATA <= 32'h0;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            mode_q   <= `SC0_RST_MODE;                         // R2
            busctl_q <= `SC0_RST_BUSCTL;
            sva_q    <= `SC0_RST_SVA;
            port_q   <= `SC0_RST_PORT;                         // R20
        end else if (wr) begin
            case (PADDR)
                `SC0_OFF_MODE:   mode_q <= PWDATA[7:0];
                `SC0_OFF_BUSCTL: busctl_q <= {PWDATA[7:2], 2'b00};
                `SC0_OFF_SVA:    sva_q <= PWDATA[7:0];
                `SC0_OFF_PORT:   port_q <= {6'h0, PWDATA[`SC0_PORT_CLK],
                                            1'b0};             // R20
                default:         ;
            endcase
        end
    end

    // Transfer sequencing
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            state_q <= SC0_IDLE;
            bits_q  <= 4'd0;
        end else if (mode == SC0_STOP || !en) begin
            state_q <= SC0_IDLE;                               // R1
            bits_q  <= 4'd0;
        end else begin
            case (state_q)
                SC0_IDLE: begin
                    // Enabling later does not start a stored byte
                    if (wr_shift && clk_s) begin               // R14 R15 R26
                        bits_q  <= 4'd0;
                        state_q <= (bus && !dl_s) ? SC0_WAIT_READY
                                                  : SC0_RUN;   // R18
                    end
                end
                SC0_WAIT_READY: begin
                    if (dl_s) begin
                        state_q <= SC0_RUN;                    // R18
                    end
                end
                SC0_RUN: begin
                    if (done) begin
                        state_q <= SC0_IDLE;                   // R5
                    end else if (sclk_rise) begin
                        bits_q <= bits_q + 4'd1;
                    end
                end
                default: state_q <= SC0_IDLE;
            endcase
        end
    end

    // Shift register and output latch
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            sr_q        <= 8'h00;
            out_latch_q <= 1'b1;
        end else if (run) begin
            if (sclk_fall && bits_q < `SC0_DATA_BITS) begin
                out_latch_q <= sr_q[7];                        // R3 R9 R11
            end else if (sclk_fall) begin
                out_latch_q <= !gate_ok;                       // R24
            end else if (sclk_rise && bits_q < `SC0_DATA_BITS) begin
                sr_q <= rx_next;                               // R4 R9 R11
            end
            if (done && bus) begin
                out_latch_q <= 1'b1;
            end
        end else if (wr && state_q == SC0_IDLE) begin
            if (PADDR == `SC0_OFF_SHIFT) begin
                sr_q <= wr_ord;                                // R1 R8
            end else if (PADDR == `SC0_OFF_BUSCTL) begin
                if (PWDATA[`SC0_BC_REL_TRIG]) begin
                    out_latch_q <= 1'b1;                       // R6
                end else if (PWDATA[`SC0_BC_CMD_TRIG]) begin
                    out_latch_q <= 1'b0;                       // R6
                end
            end
        end
    end

    // Address match, frame type and the transfer flag
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            match_q <= 1'b0;
            frame_q <= SC0_FRAME_DATA;
            irq_q   <= 1'b0;
        end else begin
            if (run && sclk_rise && bits_q == `SC0_DATA_BITS - 4'd1) begin
                match_q <= release_detected_q && (rx_next == sva_q);       // R13
            end
            if (done) begin
                frame_q <= release_detected_q ? SC0_FRAME_ADDR
                         : command_detected_q ? SC0_FRAME_CMD
                                  : SC0_FRAME_DATA;            // R12
            end
            // A set in the clearing cycle wins
            if (wr && PADDR == `SC0_OFF_STATUS && PWDATA[`SC0_ST_IRQ]) begin
                irq_q <= 1'b0;
            end
            if (done && gate_ok) begin
                irq_q <= 1'b1;                                 // R5 R13 R25
            end
        end
    end

    // Release and command conditions on the selected line
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            release_detected_q <= 1'b0;
            command_detected_q <= 1'b0;
        end else begin
            if (done) begin
                release_detected_q <= 1'b0;
                command_detected_q <= 1'b0;
            end
            if (bus && en && clk_s && clk_p_q) begin
                if (dl_s && !dl_p_q) begin
                    release_detected_q <= 1'b1;                            // R22
                    command_detected_q <= 1'b0;                            // R22
                end else if (!dl_s && dl_p_q) begin
                    command_detected_q <= 1'b1;                            // R23
                end
            end
        end
    end

    // Internal serial clock: held high while idle, rising edge last
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            gen_q   <= 1'b1;
            gcnt_q  <= 8'h00;
            grise_q <= 4'd0;
        end else if (run && mode_q[`SC0_MODE_INT] && grise_q < last) begin
            if (gcnt_q == 8'(CLK_HALF - 1)) begin
                gcnt_q <= 8'h00;
                gen_q  <= !gen_q;
                if (!gen_q) begin
                    grise_q <= grise_q + 4'd1;
                end
            end else begin
                gcnt_q <= gcnt_q + 8'h01;
            end
        end else begin
            gen_q  <= 1'b1;                                    // R19 R26
            gcnt_q <= 8'h00;
            if (!run) begin
                grise_q <= 4'd0;
            end
        end
    end

    // Pins; wake-up keeps the pull-down off while a byte comes in
    assign od_drive = !out_latch_q
                   && !(bus && wakeup_enable && run && bits_q < `SC0_DATA_BITS); // R17

    assign CH0_CLOCK_PIN_O  = gen_q & port_q[`SC0_PORT_CLK];   // R19 R20
    assign CH0_CLOCK_PIN_OE = en && mode_q[`SC0_MODE_INT]
                           && (mode != SC0_STOP);              // R2

    always_comb begin
        BUS_LINE_A_O  = 1'b0;
        BUS_LINE_A_OE = 1'b0;                                  // R2
        BUS_LINE_B_O  = 1'b0;
        BUS_LINE_B_OE = 1'b0;
        if (en) begin
            case (mode)
                SC0_THREE_WIRE: begin
                    BUS_LINE_A_O  = out_latch_q;               // R3 R6
                    BUS_LINE_A_OE = 1'b1;
                end
                SC0_TWO_WIRE, SC0_ADDR_BUS: begin
                    if (mode_q[`SC0_MODE_LINE]) begin
                        BUS_LINE_B_OE = od_drive;              // R9 R10
                    end else begin
                        BUS_LINE_A_OE = od_drive;              // R9 R10
                    end
                end
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);

    a_stop_no_shift: assert property (
        mode == SC0_STOP && !wr_shift |=> $stable(sr_q)) // R1
        else $error("shift register changed in stop mode");

    a_reset_gives_stop: assert property (
        $rose(RST_B) |-> mode == SC0_STOP && !BUS_LINE_A_OE
                         && !BUS_LINE_B_OE && port_q[`SC0_PORT_CLK]) // R2
        else $error("reset did not give stop mode");

    a_done_sets_flag: assert property (
        done && gate_ok |=> irq_q && state_q == SC0_IDLE) // R5
        else $error("flag not set after transfer");

    a_ninth_edge: assert property (
        done && bus |-> bits_q == 4'd8 && $rose(clk_s)) // R25
        else $error("bus frame not ended at ninth rising edge");

    a_wakeup_gate: assert property (
        done && bus && wakeup_enable && !match_q |=> $stable(irq_q)) // R13
        else $error("flag set without address match");

    a_late_enable: assert property (
        wr_shift && !en |=> state_q == SC0_IDLE [*2]) // R15
        else $error("transfer started while disabled");

    a_busy_holds: assert property (
        state_q == SC0_WAIT_READY && !dl_s && en && bus
        |=> state_q == SC0_WAIT_READY) // R18
        else $error("transfer left busy wait early");

    a_idle_clock_high: assert property (
        state_q == SC0_IDLE |=> CH0_CLOCK_PIN_O == port_q[1]) // R19
        else $error("idle clock not at port latch level");

    a_release_flags: assert property (
        bus && en && clk_s && clk_p_q && dl_s && !dl_p_q
        |=> release_detected_q && !command_detected_q) // R22
        else $error("release condition not recorded");

    a_wakeup_od_off: assert property (
        bus && wakeup_enable && run && bits_q < 4'd8 |-> !BUS_LINE_A_OE
                                           && !BUS_LINE_B_OE) // R17
        else $error("pull-down on during wake-up reception");

endmodule

`default_nettype wire

// file: sc0_consts.svh
// Constants for serial channel 0: register offsets, field positions,
// reset values and timing counts. Definitions only.
`ifndef SC0_CONSTS_SVH
`define SC0_CONSTS_SVH

// APB byte offsets
`define SC0_OFF_SHIFT   12'h000
`define SC0_OFF_MODE    12'h004
`define SC0_OFF_BUSCTL  12'h008
`define SC0_OFF_SVA     12'h00c
`define SC0_OFF_STATUS  12'h010
`define SC0_OFF_PORT    12'hff0

// Mode register fields
`define SC0_MODE_EN     7
`define SC0_MODE_SEL_HI 5
`define SC0_MODE_SEL_LO 4
`define SC0_MODE_LINE   3
`define SC0_MODE_LSB    2
`define SC0_MODE_INT    1

// Bus control register fields
`define SC0_BC_REL_TRIG 0
`define SC0_BC_CMD_TRIG 1
`define SC0_BC_WAKEUP   4

// Status register fields
`define SC0_ST_RELEASE_DETECTED     0
`define SC0_ST_COMMAND_DETECTED     1
`define SC0_ST_IRQ      2
`define SC0_ST_ACTIVE   5
`define SC0_ST_MATCH    6

// Port latch register
`define SC0_PORT_CLK    1

// Reset values
`define SC0_RST_MODE    8'h00
`define SC0_RST_PORT    8'h02
`define SC0_RST_BUSCTL  8'h00
`define SC0_RST_SVA     8'h00

// Frame lengths in serial clocks
`define SC0_DATA_BITS   4'd8
`define SC0_BUS_BITS    4'd9

// Half period of the generated serial clock, in MCLK cycles
`define SC0_CLK_HALF    8

`endif

// file: sc0_pkg.sv
// Types shared by the serial channel 0 design.
// Assumes nothing beyond a SystemVerilog compiler.
package sc0_pkg;

    typedef enum logic [1:0] {
        SC0_STOP,
        SC0_THREE_WIRE,
        SC0_TWO_WIRE,
        SC0_ADDR_BUS
    } sc0_mode_e;

    typedef enum logic [1:0] {
        SC0_IDLE,
        SC0_WAIT_READY,
        SC0_RUN
    } sc0_state_e;

    typedef enum logic [1:0] {
        SC0_FRAME_DATA,
        SC0_FRAME_CMD,
        SC0_FRAME_ADDR
    } sc0_frame_e;

endpackage

// file: sc0_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes each input is a level from outside the MCLK domain.
`timescale 1ns/100ps
`default_nettype none

module sc0_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    meta_q[i]   <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    meta_q[i]   <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: sc0_peer.sv
// Behavioural far-side device on the serial lines of channel 0.
// Assumes the bench resolves pull-ups and feeds back the wire levels.
`timescale 1ns/100ps
`default_nettype none

module sc0_peer (
    // Wire levels seen by the peer
    input  wire logic       sck,
    input  wire logic       rx_line,
    // Peer outputs
    output var  logic       tx_low,
    output var  logic       ext_sck,
    output var  logic [7:0] rx_byte
);
    logic [7:0] sh;
    int         cnt;

    initial begin
        tx_low  = 1'b0;
        ext_sck = 1'b1;
        rx_byte = 8'h00;
        sh      = 8'hff;
        cnt     = 8;
    end

    // A one is sent by letting the pull-up win
    always @(negedge sck) begin
        tx_low <= ~sh[7];
        sh     <= {sh[6:0], 1'b1};
    end

    // Only the first eight rising edges carry data; the ninth is the ack
    always @(posedge sck) begin
        if (cnt < 8) begin
            rx_byte <= {rx_byte[6:0], rx_line};
            cnt     <= cnt + 1;
        end
    end

    task automatic load(input logic [7:0] b);
        sh  = b;
        cnt = 0;
    endtask

    task automatic set_low(input logic v);
        tx_low = v;
    endtask

    // Release then command; line stays low until the first bit goes out
    task automatic rel_cmd;
        tx_low = 1'b1;
        #40 tx_low = 1'b0;
        #40 tx_low = 1'b1;
        #40;
    endtask

    // Clock stands high outside frames, 64 ns period inside
    task automatic run_clock(input int n);
        repeat (n) begin
            #32 ext_sck = 1'b0;
            #32 ext_sck = 1'b1;
        end
    endtask
endmodule

`default_nettype wire

// file: serial_channel0_modes_bench.sv
// Self-checking bench for serial channel 0 over APB with a peer device.
// Assumes pull-ups on the clock line and both data lines.
`timescale 1ns/100ps
`default_nettype none
`include "sc0_consts.svh"

module serial_channel0_modes_bench;
    logic        mclk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready, pslverr, clk_o, clk_oe, a_o, a_oe, b_o, b_oe;
    logic        p_low, ext_sck, ack_lvl, e;
    logic [7:0]  rx, a;
    logic        use_b   = 1'b1;
    logic [31:0] r;
    int          n_fail  = 0;
    int          n_tests = 0;
    int          n_rise  = 0;
    int          cyc     = 0;
    wire         sck;
    wire         line_a;
    wire         line_b;

    always #2.5 mclk = ~mclk;

    // Pull-ups win unless some party pulls low
    assign sck    = clk_oe ? clk_o : ext_sck;
    assign line_a = ~((a_oe & ~a_o) | (p_low & ~use_b));
    assign line_b = ~((b_oe & ~b_o) | (p_low & use_b));

    sc0_channel0 #(.CLK_HALF(8)) u_dut (
        .MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CH0_CLOCK_PIN_I(sck),
        .CH0_CLOCK_PIN_O(clk_o), .CH0_CLOCK_PIN_OE(clk_oe),
        .BUS_LINE_A_I(line_a), .BUS_LINE_A_O(a_o), .BUS_LINE_A_OE(a_oe),
        .BUS_LINE_B_I(line_b), .BUS_LINE_B_O(b_o), .BUS_LINE_B_OE(b_oe)
    );

    sc0_peer u_peer (
        .sck(sck), .rx_line(line_a), .tx_low(p_low),
        .ext_sck(ext_sck), .rx_byte(rx)
    );

    // The ack is judged just before the ninth rising edge lands
    always @(posedge sck) begin
        if (n_rise == 8)
            ack_lvl = line_a;
        n_rise++;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [11:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= wr_en;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        // Ends when pready is high, else at the bench timeout
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, ad, d, x, y);
    endtask

    task automatic rdc(input logic [11:0] ad, input logic [31:0] m,
                       input logic [31:0] x);
        logic [31:0] v;
        logic        y;
        apb(1'b0, ad, 32'h0, v, y);
        chk(v & m, x);
    endtask

    // Polls the transfer flag, checks it and clears it
    task automatic wait_flag;
        logic [31:0] v;
        logic        y;
        int          n;
        v = 32'h0;
        for (n = 0; n < 200 && v[`SC0_ST_IRQ] !== 1'b1; n++)
            apb(1'b0, `SC0_OFF_STATUS, 32'h0, v, y);
        chk({31'h0, v[`SC0_ST_IRQ]}, 32'h1);
        wr(`SC0_OFF_STATUS, 32'h4);
    endtask

    // Edges reach the flags three cycles after the pin moves
    task automatic line(input logic v);
        u_peer.set_low(v);
        repeat (5) @(posedge mclk);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        mclk  = 1'b0;
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        rdc(`SC0_OFF_MODE, 32'hffffffff, 32'h0);
        rdc(`SC0_OFF_PORT, 32'hffffffff, 32'h2);
        chk({28'h0, clk_oe, a_oe, b_oe, clk_o}, 32'h1);
        apb(1'b0, 12'h020, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        $display("test reset done");
        wr(`SC0_OFF_SHIFT, 32'h3c);
        rdc(`SC0_OFF_SHIFT, 32'hff, 32'h3c);
        n_rise = 0;
        wr(`SC0_OFF_MODE, 32'h92);
        repeat (40) @(posedge mclk);
        chk(n_rise, 32'h0);
        rdc(`SC0_OFF_STATUS, 32'h24, 32'h0);
        $display("test stop mode done");
        u_peer.load(8'h5a);
        n_rise = 0;
        wr(`SC0_OFF_SHIFT, 32'ha5);
        wait_flag();
        chk(n_rise, 32'h8);
        chk({31'h0, sck}, 32'h1);
        rdc(`SC0_OFF_SHIFT, 32'hff, 32'h5a);
        chk({24'h0, rx}, 32'ha5);
        wr(`SC0_OFF_MODE, 32'h96);
        u_peer.load(8'h03);
        wr(`SC0_OFF_SHIFT, 32'h01);
        wait_flag();
        rdc(`SC0_OFF_SHIFT, 32'hff, 32'hc0);
        chk({24'h0, rx}, 32'h80);
        $display("test three wire done");
        wr(`SC0_OFF_BUSCTL, 32'h2);
        @(negedge mclk);
        chk({31'h0, line_a}, 32'h0);
        rdc(`SC0_OFF_BUSCTL, 32'h3, 32'h0);
        wr(`SC0_OFF_BUSCTL, 32'h1);
        @(negedge mclk);
        chk({31'h0, line_a}, 32'h1);
        wr(`SC0_OFF_PORT, 32'h0);
        @(negedge mclk);
        chk({30'h0, clk_oe, clk_o}, 32'h2);
        wr(`SC0_OFF_PORT, 32'h2);
        @(negedge mclk);
        chk({30'h0, clk_oe, clk_o}, 32'h3);
        $display("test pin control done");
        // Receive on line B first, then send on line A
        wr(`SC0_OFF_MODE, 32'haa);
        u_peer.load(8'hc3);
        wr(`SC0_OFF_SHIFT, 32'hff);
        wait_flag();
        rdc(`SC0_OFF_SHIFT, 32'hff, 32'hc3);
        use_b = 1'b0;
        wr(`SC0_OFF_MODE, 32'ha2);
        u_peer.load(8'hff);
        // Last bit 1 leaves the line released before bus mode
        wr(`SC0_OFF_SHIFT, 32'h69);
        wait_flag();
        chk({24'h0, rx}, 32'h69);
        $display("test two wire done");
        wr(`SC0_OFF_MODE, 32'hb2);
        line(1'b1);
        rdc(`SC0_OFF_STATUS, 32'h3, 32'h2);
        line(1'b0);
        rdc(`SC0_OFF_STATUS, 32'h3, 32'h1);
        line(1'b1);
        rdc(`SC0_OFF_STATUS, 32'h3, 32'h3);
        u_peer.load(8'hff);
        n_rise = 0;
        wr(`SC0_OFF_SHIFT, 32'hff);
        repeat (40) @(posedge mclk);
        chk(n_rise, 32'h0);
        line(1'b0);
        wait_flag();
        chk(n_rise, 32'h9);
        chk({31'h0, ack_lvl}, 32'h0);
        rdc(`SC0_OFF_SHIFT, 32'hff, 32'hff);
        $display("test bus mode done");
        wr(`SC0_OFF_MODE, 32'hb0);
        wr(`SC0_OFF_SVA, 32'h5a);
        wr(`SC0_OFF_BUSCTL, 32'h10);
        for (int i = 0; i < 2; i++) begin
            a = (i == 1) ? 8'h5a : 8'h33;
            u_peer.load(a);
            n_rise = 0;
            wr(`SC0_OFF_SHIFT, 32'h0);
            u_peer.rel_cmd();
            u_peer.run_clock(9);
            repeat (6) @(posedge mclk);
            rdc(`SC0_OFF_STATUS, 32'h4, (i == 1) ? 32'h4 : 32'h0);
            rdc(`SC0_OFF_STATUS, 32'h18, 32'h10);
            chk({24'h0, rx}, {24'h0, a});
            chk({31'h0, ack_lvl}, (i == 1) ? 32'h0 : 32'h1);
            wr(`SC0_OFF_STATUS, 32'h4);
        end
        $display("test wake-up done");
        complete_run();
    end
endmodule

`default_nettype wire
